/* File: rtl/timer_counter8.sv */
/*
  Single-channel 8-bit timer/counter with compare unit, waveform output,
  overflow and compare flags, interrupt mask and AXI4-Lite register access.
  Assumes one system clock aclk and a synchronous active-low reset.
*/
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module timer_counter8 (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Oscillator pins
  input  wire logic        crystal_in_pin,
  output logic             crystal_out_pin,
  // Waveform and interrupt
  output logic             compare_output_pin,
  output logic             irq
);

  tick_if tk ();

  logic [7:0]        aw_addr_r, aw_addr_nxt;
  logic              aw_have_r, aw_have_nxt;
  logic [31:0]       w_data_r, w_data_nxt;
  logic              w_lane_r, w_lane_nxt;
  logic              w_have_r, w_have_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic              do_wr;
  logic              wr_ok;

  logic [7:0]        cnt_r, cnt_nxt;
  logic [7:0]        cmp_buf_r, cmp_buf_nxt;
  logic [7:0]        cmp_act_r, cmp_act_nxt;
  logic [2:0]        cs_r, cs_nxt;
  logic [1:0]        mode_r, mode_nxt;
  logic [1:0]        com_r, com_nxt;
  logic              async_r, async_nxt;
  logic [1:0]        flags_r, flags_nxt;
  logic [1:0]        mask_r, mask_nxt;
  logic              block_r, block_nxt;
  timer_pkg::dir_t   dir_r, dir_nxt;
  logic              oc_r, oc_nxt;
  logic              xo_r;
  logic [1:0]        flag_set;
  logic [1:0]        flag_clr;
  logic [7:0]        top;
  logic              at_bottom, at_max, at_top, pwm_mode;
  logic              match, ovf, wr_cnt;

  timer_prescaler u_pre (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .clock_select_bits  (cs_r),
    .async_clock_select (async_r),
    .crystal_in_pin     (crystal_in_pin),
    .tk                 (tk.src)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready  = !w_have_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  always_comb begin
    aw_addr_nxt = aw_addr_r;
    aw_have_nxt = aw_have_r;
    w_data_nxt  = w_data_r;
    w_lane_nxt  = w_lane_r;
    w_have_nxt  = w_have_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    do_wr       = aw_have_r && w_have_r && !bvalid_r;
    wr_ok       = 1'b0;
    case (aw_addr_r)
      timer_pkg::OFF_COUNT, timer_pkg::OFF_COMPARE, timer_pkg::OFF_CTRL,
      timer_pkg::OFF_ASYNC, timer_pkg::OFF_FLAG, timer_pkg::OFF_FLAG_CLR,
      timer_pkg::OFF_MASK: wr_ok = 1'b1;
      default:             wr_ok = 1'b0;
    endcase
    if (s_axi_awvalid && !aw_have_r) begin
      aw_addr_nxt = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && !w_have_r) begin
      w_data_nxt = s_axi_wdata;
      w_lane_nxt = s_axi_wstrb[0];
      w_have_nxt = 1'b1;
    end
    if (do_wr) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLV;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = timer_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      case (s_axi_araddr)
        timer_pkg::OFF_COUNT:    rdata_nxt[7:0] = cnt_r;
        timer_pkg::OFF_COMPARE:  rdata_nxt[7:0] = cmp_buf_r;
        timer_pkg::OFF_CTRL: begin
          rdata_nxt[timer_pkg::CTRL_CS_LSB +: 3]   = cs_r;
          rdata_nxt[timer_pkg::CTRL_MODE_LSB +: 2] = mode_r;
          rdata_nxt[timer_pkg::CTRL_COM_LSB +: 2]  = com_r;
        end
        timer_pkg::OFF_ASYNC: begin
          rdata_nxt[timer_pkg::ASYNC_SEL_BIT] = async_r;
          rdata_nxt[timer_pkg::ASYNC_BOT_BIT] = at_bottom;
          rdata_nxt[timer_pkg::ASYNC_MAX_BIT] = at_max;
          rdata_nxt[timer_pkg::ASYNC_TOP_BIT] = at_top;
        end
        timer_pkg::OFF_FLAG:     rdata_nxt[1:0] = flags_r;
        timer_pkg::OFF_FLAG_CLR: rdata_nxt[1:0] = 2'h0;
        timer_pkg::OFF_MASK:     rdata_nxt[1:0] = mask_r;
        default:                 rresp_nxt = timer_pkg::RESP_SLV;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_r <= 8'h00;
      aw_have_r <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_lane_r  <= 1'b0;
      w_have_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= timer_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= timer_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      aw_addr_r <= aw_addr_nxt;
      aw_have_r <= aw_have_nxt;
      w_data_r  <= w_data_nxt;
      w_lane_r  <= w_lane_nxt;
      w_have_r  <= w_have_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Counter, compare unit, flags and waveform
  // ---------------------------------------------------------------
  always_comb begin
    cnt_nxt     = cnt_r;
    cmp_buf_nxt = cmp_buf_r;
    cmp_act_nxt = cmp_act_r;
    cs_nxt      = cs_r;
    mode_nxt    = mode_r;
    com_nxt     = com_r;
    async_nxt   = async_r;
    mask_nxt    = mask_r;
    dir_nxt     = dir_r;
    oc_nxt      = oc_r;
    flag_set    = 2'h0;
    flag_clr    = 2'h0;
    ovf         = 1'b0;
    pwm_mode    = (mode_r == timer_pkg::MODE_PWM_PC) || (mode_r == timer_pkg::MODE_PWM_FS);
    top         = (mode_r == timer_pkg::MODE_CTC) ? cmp_act_r : timer_pkg::CNT_MAX;
    at_bottom   = (cnt_r == timer_pkg::CNT_BOTTOM);
    at_max      = (cnt_r == timer_pkg::CNT_MAX);
    at_top      = (cnt_r == top);
    match       = tk.tick && (cnt_r == cmp_act_r) && !block_r;
    wr_cnt      = do_wr && w_lane_r && (aw_addr_r == timer_pkg::OFF_COUNT);
    block_nxt   = wr_cnt ? 1'b1 : (tk.tick ? 1'b0 : block_r);

    if (tk.tick) begin
      case (mode_r)
        timer_pkg::MODE_PWM_PC: begin
          if (dir_r == timer_pkg::DIR_UP) begin
            if (at_max) begin
              dir_nxt     = timer_pkg::DIR_DOWN;
              cnt_nxt     = cnt_r - 8'h01;
              cmp_act_nxt = cmp_buf_r;
            end else begin
              cnt_nxt = cnt_r + 8'h01;
            end
          end else if (at_bottom) begin
            dir_nxt = timer_pkg::DIR_UP;
            cnt_nxt = cnt_r + 8'h01;
            ovf     = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 8'h01;
          end
          if (match && com_r[1]) begin
            oc_nxt = (dir_r == timer_pkg::DIR_UP) ^ com_r[0] ? 1'b0 : 1'b1;
          end
        end
        timer_pkg::MODE_PWM_FS: begin
          cnt_nxt = at_max ? timer_pkg::CNT_BOTTOM : cnt_r + 8'h01;
          ovf     = at_max;
          if (at_max) begin
            cmp_act_nxt = cmp_buf_r;
          end
          if (com_r[1]) begin
            if (match) begin
              oc_nxt = com_r[0];
            end else if (at_max) begin
              oc_nxt = !com_r[0];
            end
          end
        end
        default: begin
          cnt_nxt = (at_top || at_max) ? timer_pkg::CNT_BOTTOM : cnt_r + 8'h01;
          ovf     = at_max;
          if (match) begin
            case (com_r)
              timer_pkg::COM_TOGGLE: oc_nxt = !oc_r;
              timer_pkg::COM_CLEAR:  oc_nxt = 1'b0;
              timer_pkg::COM_SET:    oc_nxt = 1'b1;
              default:               oc_nxt = oc_r;
            endcase
          end
        end
      endcase
    end

    if (do_wr && w_lane_r) begin
      case (aw_addr_r)
        timer_pkg::OFF_COUNT:   cnt_nxt = w_data_r[7:0];
        timer_pkg::OFF_COMPARE: begin
          cmp_buf_nxt = w_data_r[7:0];
          if (!pwm_mode) begin
            cmp_act_nxt = w_data_r[7:0];
          end
        end
        timer_pkg::OFF_CTRL: begin
          cs_nxt   = w_data_r[timer_pkg::CTRL_CS_LSB +: 3];
          mode_nxt = w_data_r[timer_pkg::CTRL_MODE_LSB +: 2];
          com_nxt  = w_data_r[timer_pkg::CTRL_COM_LSB +: 2];
          dir_nxt  = timer_pkg::DIR_UP;
        end
        timer_pkg::OFF_ASYNC:    async_nxt = w_data_r[timer_pkg::ASYNC_SEL_BIT];
        timer_pkg::OFF_FLAG_CLR: flag_clr  = w_data_r[1:0];
        timer_pkg::OFF_MASK:     mask_nxt  = w_data_r[1:0];
        default:                 flag_clr  = 2'h0;
      endcase
    end

    flag_set[timer_pkg::FLAG_CMP_BIT] = match;
    flag_set[timer_pkg::FLAG_OVF_BIT] = ovf;
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r     <= timer_pkg::CNT_RST;
      cmp_buf_r <= timer_pkg::CMP_RST;
      cmp_act_r <= timer_pkg::CMP_RST;
      cs_r      <= timer_pkg::CS_RST;
      mode_r    <= timer_pkg::MODE_NORMAL;
      com_r     <= timer_pkg::COM_OFF;
      async_r   <= 1'b0;
      flags_r   <= timer_pkg::FLAG_RST;
      mask_r    <= timer_pkg::FLAG_RST;
      block_r   <= 1'b0;
      dir_r     <= timer_pkg::DIR_UP;
      oc_r      <= 1'b0;
      xo_r      <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      cmp_buf_r <= cmp_buf_nxt;
      cmp_act_r <= cmp_act_nxt;
      cs_r      <= cs_nxt;
      mode_r    <= mode_nxt;
      com_r     <= com_nxt;
      async_r   <= async_nxt;
      flags_r   <= flags_nxt;
      mask_r    <= mask_nxt;
      block_r   <= block_nxt;
      dir_r     <= dir_nxt;
      oc_r      <= oc_nxt;
      xo_r      <= !crystal_in_pin;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign compare_output_pin = oc_r;
  assign crystal_out_pin    = xo_r;
  assign irq                = |(flags_r & mask_r);

endmodule : timer_counter8

`default_nettype wire

/* File: rtl/timer_pkg.sv */
/*
  Constants for the 8-bit timer/counter: register offsets, field positions,
  reset values, prescaler tap masks and counting modes.
  Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package timer_pkg;

  // ---------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_COUNT    = 8'h00;
  localparam logic [7:0] OFF_COMPARE  = 8'h04;
  localparam logic [7:0] OFF_CTRL     = 8'h08;
  localparam logic [7:0] OFF_ASYNC    = 8'h0C;
  localparam logic [7:0] OFF_FLAG     = 8'h10;
  localparam logic [7:0] OFF_FLAG_CLR = 8'h14;
  localparam logic [7:0] OFF_MASK     = 8'h18;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_CS_LSB   = 0;
  localparam int CTRL_MODE_LSB = 3;
  localparam int CTRL_COM_LSB  = 5;
  localparam int ASYNC_SEL_BIT = 0;
  localparam int ASYNC_BOT_BIT = 1;
  localparam int ASYNC_MAX_BIT = 2;
  localparam int ASYNC_TOP_BIT = 3;
  localparam int FLAG_OVF_BIT  = 0;
  localparam int FLAG_CMP_BIT  = 1;

  // ---------------------------------------------------------------
  // Values and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_RST    = 8'h00;
  localparam logic [7:0] CMP_RST    = 8'h00;
  localparam logic [2:0] CS_RST     = 3'h0;
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [1:0] FLAG_RST   = 2'h0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  // ---------------------------------------------------------------
  // Counting modes and compare output actions
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PWM_PC = 2'h1;
  localparam logic [1:0] MODE_CTC    = 2'h2;
  localparam logic [1:0] MODE_PWM_FS = 2'h3;
  localparam logic [1:0] COM_OFF     = 2'h0;
  localparam logic [1:0] COM_TOGGLE  = 2'h1;
  localparam logic [1:0] COM_CLEAR   = 2'h2;
  localparam logic [1:0] COM_SET     = 2'h3;

  // ---------------------------------------------------------------
  // Prescaler tap masks (division 1, 8, 32, 64, 128, 256, 1024)
  // ---------------------------------------------------------------
  localparam int         PRE_W      = 10;
  localparam logic [9:0] PRE_DIV1   = 10'h000;
  localparam logic [9:0] PRE_DIV8   = 10'h007;
  localparam logic [9:0] PRE_DIV32  = 10'h01F;
  localparam logic [9:0] PRE_DIV64  = 10'h03F;
  localparam logic [9:0] PRE_DIV128 = 10'h07F;
  localparam logic [9:0] PRE_DIV256 = 10'h0FF;
  localparam logic [9:0] PRE_DIV1K  = 10'h3FF;

  typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

endpackage : timer_pkg

/* File: rtl/tick_if.sv */
/*
  Carries the timer clock enable from the prescaler to the counter.
  Assumes both ends run on the one system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface : tick_if

`default_nettype wire

/* File: rtl/timer_prescaler.sv */
/*
  Clock select and prescaler: picks the system clock or the synchronised
  crystal oscillator, divides it and emits a one-cycle timer clock enable.
  Assumes the crystal input is far slower than aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_prescaler (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Settings
  input  wire logic [2:0] clock_select_bits,
  input  wire logic       async_clock_select,
  // Oscillator
  input  wire logic       crystal_in_pin,
  // Timer clock enable
  tick_if.src             tk
);

  logic                           xs1_r, xs2_r, xs3_r;
  logic [timer_pkg::PRE_W-1:0]    pre_r, pre_nxt;
  logic [timer_pkg::PRE_W-1:0]    mask;
  logic                           base_en;

  // ---------------------------------------------------------------
  // Oscillator synchroniser and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
    end else begin
      xs1_r <= crystal_in_pin;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
    end
  end

  // ---------------------------------------------------------------
  // Source select and divider
  // ---------------------------------------------------------------
  always_comb begin
    base_en = async_clock_select ? (xs2_r & ~xs3_r) : 1'b1;
    pre_nxt = base_en ? pre_r + 10'h001 : pre_r;
    case (clock_select_bits)
      3'h1:    mask = timer_pkg::PRE_DIV1;
      3'h2:    mask = timer_pkg::PRE_DIV8;
      3'h3:    mask = timer_pkg::PRE_DIV32;
      3'h4:    mask = timer_pkg::PRE_DIV64;
      3'h5:    mask = timer_pkg::PRE_DIV128;
      3'h6:    mask = timer_pkg::PRE_DIV256;
      3'h7:    mask = timer_pkg::PRE_DIV1K;
      default: mask = timer_pkg::PRE_DIV1;
    endcase
    tk.tick = base_en && (clock_select_bits != timer_pkg::CS_STOP)
              && ((pre_r & mask) == mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

endmodule : timer_prescaler

`default_nettype wire

/* File: sim/timer_counter8_checker.sv */
/*
  Concurrent checks on the timer/counter top-level ports.
  Assumes one clock aclk and a synchronous active-low reset aresetn.
*/
`timescale 1ns/1ps
`default_nettype none

module timer_counter8_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Read channels
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins
  input wire logic        crystal_in_pin,
  input wire logic        crystal_out_pin,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_bad;
    s_rd_take ##0 (s_axi_araddr > 8'h18 || s_axi_araddr[1:0] != 2'h0);
  endsequence

  chk_wr_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read data late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rd_gap: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data stuck");
  chk_unmapped_read: assert property (s_rd_bad |=> s_axi_rresp == timer_pkg::RESP_SLV && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  chk_xtal_invert: assert property ($past(aresetn) |-> crystal_out_pin == !$past(crystal_in_pin))
    else $error("oscillator output wrong");
  chk_irq_quiet: assert property ($rose(aresetn) |-> !irq)
    else $error("interrupt high after reset");
endmodule : timer_counter8_checker

bind timer_counter8 timer_counter8_checker timer_counter8_checker_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .crystal_in_pin(crystal_in_pin), .crystal_out_pin(crystal_out_pin), .irq(irq));

`default_nettype wire

/* File: sim/testbench.sv */
/*
  Self-checking bench for the timer/counter, driving AXI4-Lite and the crystal pin.
  Assumes timer_pkg offsets and a 25 MHz aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, xtal_in;
  logic        awready, wready, bvalid, arready, rvalid, xtal_out, oc_pin, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          err_count, samples_checked;

  timer_counter8 timer_counter8_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .crystal_in_pin(xtal_in),
    .crystal_out_pin(xtal_out), .compare_output_pin(oc_pin), .irq(irq));

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  task end_sim;
    if (err_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'h1) begin
        aw_ok = 1'h1;
        awvalid <= 1'h0;
      end
      if (!w_ok && wready === 1'h1) begin
        w_ok = 1'h1;
        wvalid <= 1'h0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
    check({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task rd(input logic [7:0] a, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    d = rdata;
    rready <= 1'h0;
    check({30'h0, rresp}, {30'h0, er});
  endtask : rd

  task pulse(input int n);
    repeat (n) begin
      repeat (8) @(posedge aclk);
      xtal_in <= 1'h1;
      repeat (8) @(posedge aclk);
      xtal_in <= 1'h0;
    end
  endtask : pulse

  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    end_sim();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, xtal_in} = 7'h0;
    {awaddr, araddr, wdata, d} = 80'h0;
    wstrb = 4'hF;
    err_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      if (i != 3) begin
        rd(8'(i * 4), timer_pkg::RESP_OKAY);
        check(d, 32'h0);
      end
    end
    rd(8'h1C, timer_pkg::RESP_SLV);
    check(d, 32'h0);
    wr(8'h1C, 32'h0000_0001, timer_pkg::RESP_SLV);
    // ---------------------------------------------------------------
    // Stopped counter keeps CPU value; status flags
    // ---------------------------------------------------------------
    wr(timer_pkg::OFF_COUNT, 32'h1234_56A5, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_COMPARE, 32'h0000_FF3C, timer_pkg::RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(timer_pkg::OFF_COUNT, timer_pkg::RESP_OKAY);
    check(d, 32'h0000_00A5);
    rd(timer_pkg::OFF_COMPARE, timer_pkg::RESP_OKAY);
    check(d, 32'h0000_003C);
    wr(timer_pkg::OFF_COUNT, 32'h0000_0000, timer_pkg::RESP_OKAY);
    rd(timer_pkg::OFF_ASYNC, timer_pkg::RESP_OKAY);
    check(d & 32'h0000_0006, 32'h0000_0002);
    wr(timer_pkg::OFF_COUNT, 32'h0000_00FF, timer_pkg::RESP_OKAY);
    rd(timer_pkg::OFF_ASYNC, timer_pkg::RESP_OKAY);
    check(d & 32'h0000_0006, 32'h0000_0004);
    // ---------------------------------------------------------------
    // Compare flag, mask and clear
    // ---------------------------------------------------------------
    wr(timer_pkg::OFF_COMPARE, 32'h0000_0040, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_COUNT, 32'h0000_0030, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0001, timer_pkg::RESP_OKAY);
    repeat (40) @(posedge aclk);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0000, timer_pkg::RESP_OKAY);
    rd(timer_pkg::OFF_FLAG, timer_pkg::RESP_OKAY);
    check(d, 32'h0000_0002);
    check({31'h0, irq}, 32'h0);
    wr(timer_pkg::OFF_MASK, 32'h0000_0002, timer_pkg::RESP_OKAY);
    check({31'h0, irq}, 32'h1);
    wr(timer_pkg::OFF_FLAG, 32'h0000_0000, timer_pkg::RESP_OKAY);
    rd(timer_pkg::OFF_FLAG, timer_pkg::RESP_OKAY);
    check(d, 32'h0000_0002);
    wr(timer_pkg::OFF_FLAG_CLR, 32'h0000_0002, timer_pkg::RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    // ---------------------------------------------------------------
    // Overflow at 255 on the system clock
    // ---------------------------------------------------------------
    wr(timer_pkg::OFF_COUNT, 32'h0000_00F0, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0001, timer_pkg::RESP_OKAY);
    repeat (30) @(posedge aclk);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0000, timer_pkg::RESP_OKAY);
    rd(timer_pkg::OFF_FLAG, timer_pkg::RESP_OKAY);
    check(d, 32'h0000_0001);
    wr(timer_pkg::OFF_FLAG_CLR, 32'h0000_0003, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_MASK, 32'h0000_0003, timer_pkg::RESP_OKAY);
    // ---------------------------------------------------------------
    // Counter write blocks the next match
    // ---------------------------------------------------------------
    wr(timer_pkg::OFF_COMPARE, 32'h0000_0050, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_COUNT, 32'h0000_0050, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0001, timer_pkg::RESP_OKAY);
    repeat (10) @(posedge aclk);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0000, timer_pkg::RESP_OKAY);
    rd(timer_pkg::OFF_FLAG, timer_pkg::RESP_OKAY);
    check(d, 32'h0000_0000);
    check({31'h0, irq}, 32'h0);
    // ---------------------------------------------------------------
    // Clear on compare: top is the compare value
    // ---------------------------------------------------------------
    wr(timer_pkg::OFF_COMPARE, 32'h0000_0005, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_COUNT, 32'h0000_0000, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0011, timer_pkg::RESP_OKAY);
    repeat (50) @(posedge aclk);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0000, timer_pkg::RESP_OKAY);
    rd(timer_pkg::OFF_COUNT, timer_pkg::RESP_OKAY);
    check({31'h0, d <= 32'h0000_0005}, 32'h1);
    check({31'h0, irq}, 32'h1);
    // ---------------------------------------------------------------
    // Crystal clocking: counts only crystal rising edges
    // ---------------------------------------------------------------
    wr(timer_pkg::OFF_COUNT, 32'h0000_0000, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_ASYNC, 32'h0000_0001, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0001, timer_pkg::RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(timer_pkg::OFF_COUNT, timer_pkg::RESP_OKAY);
    check(d, 32'h0000_0000);
    pulse(6);
    repeat (10) @(posedge aclk);
    rd(timer_pkg::OFF_COUNT, timer_pkg::RESP_OKAY);
    check(d, 32'h0000_0006);
    rd(timer_pkg::OFF_ASYNC, timer_pkg::RESP_OKAY);
    check(d & 32'h0000_0001, 32'h0000_0001);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0059, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_COUNT, 32'h0000_00FE, timer_pkg::RESP_OKAY);
    pulse(2);
    check({31'h0, oc_pin}, 32'h1);
    pulse(6);
    check({31'h0, oc_pin}, 32'h0);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0069, timer_pkg::RESP_OKAY);
    wr(timer_pkg::OFF_COUNT, 32'h0000_0003, timer_pkg::RESP_OKAY);
    pulse(3);
    check({31'h0, oc_pin}, 32'h1);
    end_sim();
  end
endmodule : testbench

`default_nettype wire
